/* File: rtl/rgbd_pkg.sv */
// shared constants for the rgb led modulator
package rgbd_pkg;
	localparam int RGBD_CHANNELS = 3;
	localparam int RGBD_LEVEL_W = 8;
	localparam int RGBD_ACC_W = 16;
	localparam int RGBD_CARRY_BIT = 8;
	localparam logic [RGBD_ACC_W-1:0] RGBD_ACC_MASK = 16'h00ff;
	localparam logic [RGBD_ACC_W-1:0] RGBD_ACC_RESET = 16'h0000;
	localparam int RGBD_TIMER_W = 16;
	localparam logic [RGBD_TIMER_W-1:0] RGBD_PERIOD_RESET = 16'h00ff;
	localparam logic [RGBD_TIMER_W-1:0] RGBD_TIMER_ZERO = 16'h0000;
	localparam logic [RGBD_TIMER_W-1:0] RGBD_TIMER_ONE = 16'h0001;
	localparam int RGBD_STEP_W = 16;
	localparam logic [RGBD_STEP_W-1:0] RGBD_STEP_ZERO = 16'h0000;
	localparam logic [RGBD_STEP_W-1:0] RGBD_STEP_ONE = 16'h0001;
	localparam int RGBD_STEP_NS = 1000;
	localparam int RGBD_CLK_MHZ = 200;
	localparam int RGBD_STEP_CYC = RGBD_STEP_NS * RGBD_CLK_MHZ / 1000;
	typedef enum logic [0:0] {
		RGBD_MODE_PWM = 1'b0,
		RGBD_MODE_PDM = 1'b1
	} rgbd_mode_t;
endpackage

/* File: rtl/rgbd_chan_if.sv */
// per-channel signals between top and channel slice
`timescale 1ns/10ps
interface rgbd_chan_if;
	logic [rgbd_pkg::RGBD_LEVEL_W-1:0] level;
	logic [rgbd_pkg::RGBD_TIMER_W-1:0] duty;
	logic drive;
	modport top (output level, output duty, input drive);
	modport chan (input level, input duty, output drive);
endinterface

/* File: rtl/rgbd_chan.sv */
// one colour channel: duty compare and density accumulator
`timescale 1ns/10ps
module rgbd_chan import rgbd_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic pdm_mode,
	input wire logic period_start,
	input wire logic step_tick,
	input wire logic [RGBD_TIMER_W-1:0] timer_count,
	rgbd_chan_if.chan ch
);
	logic [RGBD_TIMER_W-1:0] active_compare_reg, active_compare_next;
	logic [RGBD_ACC_W-1:0] acc_reg, acc_next;
	logic drive_reg, drive_next;
	logic [RGBD_ACC_W-1:0] sum;

	always_comb begin
		sum = acc_reg + {{(RGBD_ACC_W-RGBD_LEVEL_W){1'b0}}, ch.level};
		active_compare_next = active_compare_reg;
		acc_next = acc_reg;
		drive_next = drive_reg;
		if (pdm_mode) begin
			if (step_tick) begin
				acc_next = sum & RGBD_ACC_MASK;
				drive_next = sum[RGBD_CARRY_BIT];
			end
		end else if (period_start) begin
			active_compare_next = ch.duty;
			// zero duty stays dark for the whole period
			drive_next = (ch.duty != RGBD_TIMER_ZERO);
		end else if (timer_count == active_compare_reg) begin
			drive_next = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			active_compare_reg <= RGBD_TIMER_ZERO;
			acc_reg <= RGBD_ACC_RESET;
			drive_reg <= 1'b0;
		end else begin
			active_compare_reg <= active_compare_next;
			acc_reg <= acc_next;
			drive_reg <= drive_next;
		end
	end

	assign ch.drive = drive_reg;

	AST_PDM_ONE_STEP: assert property (@(posedge clk) disable iff (reset)
		pdm_mode && step_tick && !sum[RGBD_CARRY_BIT] |=> !drive_reg)
		else $error("density pulse outlived its step");
	AST_PDM_MASK: assert property (@(posedge clk) disable iff (reset)
		acc_reg[RGBD_ACC_W-1:RGBD_CARRY_BIT] == '0)
		else $error("accumulator not masked");
	AST_PWM_LOW: assert property (@(posedge clk) disable iff (reset)
		!pdm_mode && !period_start && timer_count == active_compare_reg
		|=> !drive_reg)
		else $error("channel not low at compare match");
	AST_PWM_RELOAD: assert property (@(posedge clk) disable iff (reset)
		!pdm_mode && period_start |=> active_compare_reg == $past(ch.duty))
		else $error("compare not reloaded at period start");
endmodule

/* File: rtl/rgbd_top.sv */
// three-channel rgb led pulse-width / pulse-density modulator
`timescale 1ns/10ps
module rgbd_top import rgbd_pkg::*; #(
	parameter logic [RGBD_STEP_W-1:0] STEP_CYCLES = RGBD_STEP_CYC[RGBD_STEP_W-1:0]
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic pdm_mode,
	input wire logic [RGBD_TIMER_W-1:0] period_value,
	input wire logic [RGBD_STEP_W-1:0] step_interval,
	input wire logic [RGBD_TIMER_W-1:0] red_duty_buffer,
	input wire logic [RGBD_TIMER_W-1:0] green_duty_buffer,
	input wire logic [RGBD_TIMER_W-1:0] blue_duty_buffer,
	input wire logic [RGBD_LEVEL_W-1:0] red_level,
	input wire logic [RGBD_LEVEL_W-1:0] green_level,
	input wire logic [RGBD_LEVEL_W-1:0] blue_level,
	output logic red_drive,
	output logic green_drive,
	output logic blue_drive,
	output logic timer_period_flag
);
	logic [RGBD_TIMER_W-1:0] timer_reg, timer_next;
	logic [RGBD_STEP_W-1:0] step_cnt_reg, step_cnt_next;
	logic step_tick_reg, step_tick_next;
	logic flag_reg, flag_next;
	logic period_start;
	logic [RGBD_STEP_W-1:0] step_limit;
	rgbd_chan_if ch_r ();
	rgbd_chan_if ch_g ();
	rgbd_chan_if ch_b ();

	// software-written duty values feed buffers only; compares latch at boundary
	assign ch_r.duty = red_duty_buffer;
	assign ch_g.duty = green_duty_buffer;
	assign ch_b.duty = blue_duty_buffer;
	assign ch_r.level = red_level;
	assign ch_g.level = green_level;
	assign ch_b.level = blue_level;

	assign period_start = (timer_reg == period_value);
	// zero interval falls back to the default so steps never stall
	assign step_limit = (step_interval == RGBD_STEP_ZERO) ? STEP_CYCLES
		: step_interval;

	always_comb begin
		timer_next = timer_reg + RGBD_TIMER_ONE;
		flag_next = 1'b0;
		if (pdm_mode) begin
			timer_next = RGBD_TIMER_ZERO;
		end else if (period_start) begin
			timer_next = RGBD_TIMER_ZERO;
			flag_next = 1'b1;
		end
	end

	always_comb begin
		step_cnt_next = step_cnt_reg + RGBD_STEP_ONE;
		step_tick_next = 1'b0;
		if (step_cnt_reg >= step_limit - RGBD_STEP_ONE) begin
			step_cnt_next = RGBD_STEP_ZERO;
			step_tick_next = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			timer_reg <= RGBD_TIMER_ZERO;
			flag_reg <= 1'b0;
			step_cnt_reg <= RGBD_STEP_ZERO;
			step_tick_reg <= 1'b0;
		end else begin
			timer_reg <= timer_next;
			flag_reg <= flag_next;
			step_cnt_reg <= step_cnt_next;
			step_tick_reg <= step_tick_next;
		end
	end

	rgbd_chan u_red (.clk(clk), .reset(reset), .pdm_mode(pdm_mode),
		.period_start(period_start), .step_tick(step_tick_reg),
		.timer_count(timer_reg), .ch(ch_r));
	rgbd_chan u_green (.clk(clk), .reset(reset), .pdm_mode(pdm_mode),
		.period_start(period_start), .step_tick(step_tick_reg),
		.timer_count(timer_reg), .ch(ch_g));
	rgbd_chan u_blue (.clk(clk), .reset(reset), .pdm_mode(pdm_mode),
		.period_start(period_start), .step_tick(step_tick_reg),
		.timer_count(timer_reg), .ch(ch_b));

	assign red_drive = ch_r.drive;
	assign green_drive = ch_g.drive;
	assign blue_drive = ch_b.drive;
	assign timer_period_flag = flag_reg;

	AST_FLAG_AT_WRAP: assert property (@(posedge clk) disable iff (reset)
		!pdm_mode && period_start |=> timer_period_flag && timer_reg == '0)
		else $error("period flag or timer clear missing");
	AST_FLAG_ONE_CYCLE: assert property (@(posedge clk) disable iff (reset)
		timer_period_flag |=> !timer_period_flag || $past(period_value) == '0)
		else $error("period flag held too long");
	AST_TIMER_COUNTS: assert property (@(posedge clk) disable iff (reset)
		!pdm_mode && !period_start ##1 !pdm_mode
		|-> timer_reg == $past(timer_reg) + RGBD_TIMER_ONE)
		else $error("timer did not advance");
	AST_TICK_SINGLE: assert property (@(posedge clk) disable iff (reset)
		step_tick_reg && step_limit > RGBD_STEP_ONE |=> !step_tick_reg)
		else $error("step tick wider than one cycle");
	COV_PWM_WRAP: cover property (@(posedge clk) disable iff (reset)
		!pdm_mode && timer_period_flag ##[1:300] timer_period_flag);
	COV_PDM_PULSE: cover property (@(posedge clk) disable iff (reset)
		pdm_mode && red_drive ##1 !red_drive);
	COV_PDM_BACK2BACK: cover property (@(posedge clk) disable iff (reset)
		pdm_mode && blue_drive [*2]);
endmodule

/* File: test/rgbd_led_model.sv */
// led partner model: tallies lit cycles per colour
`timescale 1ns/10ps
module rgbd_led_model (
	input wire logic clk,
	input wire logic red_drive,
	input wire logic green_drive,
	input wire logic blue_drive,
	output int lit_cnt[3]
);
	// a bare led only integrates on-time, so unknown counts as dark
	initial lit_cnt = '{0, 0, 0};
	always @(posedge clk) begin
		lit_cnt[0] <= lit_cnt[0] + int'(red_drive === 1'b1);
		lit_cnt[1] <= lit_cnt[1] + int'(green_drive === 1'b1);
		lit_cnt[2] <= lit_cnt[2] + int'(blue_drive === 1'b1);
	end
endmodule

/* File: test/rgbd_top_test.sv */
// self-checking bench for the rgb led modulator
`timescale 1ns/10ps
module rgbd_top_test import rgbd_pkg::*; ;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic pdm_mode = 1'b0;
	logic red_drive, green_drive, blue_drive, timer_period_flag;
	logic [RGBD_TIMER_W-1:0] period_value = 16'h0007;
	logic [RGBD_STEP_W-1:0] step_interval = 16'h0001;
	logic [RGBD_TIMER_W-1:0] duty[3] = '{16'h0002, 16'h0000, 16'h0009};
	logic [RGBD_LEVEL_W-1:0] lvl[3] = '{8'h80, 8'h00, 8'hff};
	int lit_cnt[3];
	int d[3];
	int flags;
	int error_cnt = 0;
	int num_checks = 0;
	always #2.5 clk = ~clk;
	rgbd_top i_dut (.clk, .reset, .pdm_mode, .period_value, .step_interval,
		.red_duty_buffer(duty[0]), .green_duty_buffer(duty[1]),
		.blue_duty_buffer(duty[2]), .red_level(lvl[0]),
		.green_level(lvl[1]), .blue_level(lvl[2]), .red_drive,
		.green_drive, .blue_drive, .timer_period_flag);
	rgbd_led_model i_led (.clk, .red_drive, .green_drive, .blue_drive,
		.lit_cnt);
	task automatic chk(string what, int exp, int got);
		num_checks++;
		if (got != exp) begin
			error_cnt++;
			$display("Error %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// called at a falling edge; counts lit cycles of the next n cycles
	task automatic measure(int n);
		int s[3];
		s = lit_cnt;
		flags = 0;
		repeat (n) begin
			flags += int'(timer_period_flag === 1'b1);
			@(negedge clk);
		end
		foreach (d[i]) d[i] = lit_cnt[i] - s[i];
	endtask
	task automatic wait_flag();
		int k = 0;
		while (timer_period_flag !== 1'b1 && k < 40) begin
			@(negedge clk);
			k++;
		end
		if (k == 40) begin
			error_cnt++;
			close_out();
		end
	endtask
	task automatic t_pwm();
		wait_flag();
		measure(32);
		chk("red lit", 12, d[0]);
		chk("green lit", 0, d[1]);
		chk("green dark", 1, int'(green_drive === 1'b0));
		chk("blue lit", 32, d[2]);
		chk("flags", 4, flags);
		$display("pwm done");
	endtask
	task automatic t_reload();
		wait_flag();
		@(posedge clk);
		duty[0] <= 16'h0005;
		@(negedge clk);
		measure(7);
		chk("red old duty", 2, d[0]);
		measure(8);
		chk("red new duty", 6, d[0]);
		$display("reload done");
	endtask
	task automatic t_pdm();
		@(posedge clk);
		pdm_mode <= 1'b1;
		repeat (4) @(negedge clk);
		measure(256);
		chk("red density", 128, d[0]);
		chk("green density", 0, d[1]);
		chk("green pdm dark", 1, int'(green_drive === 1'b0));
		chk("blue density", 255, d[2]);
		chk("pdm flags", 0, flags);
		$display("pdm done");
	endtask
	task automatic t_step();
		int k = 0;
		int n = 0;
		@(posedge clk);
		step_interval <= 16'h0004;
		repeat (4) @(negedge clk);
		while (red_drive !== 1'b0 && k < 20) begin
			@(negedge clk);
			k++;
		end
		while (red_drive !== 1'b1 && k < 20) begin
			@(negedge clk);
			k++;
		end
		while (red_drive === 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		chk("red pulse len", 4, n);
		$display("step done");
	endtask
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		chk("idle", 1, int'({red_drive, green_drive, blue_drive,
			timer_period_flag} === 4'h0));
		t_pwm();
		t_reload();
		t_pdm();
		t_step();
		close_out();
	end
endmodule
